// ===== dv/irq_pin_vector_dispatch_tb.sv
// Self-checking bench for the request pin block and vector dispatch.
// Assumes the constants header on the include path and the pin model.
`timescale 1ns/10ps
`include "irq_pin_defs.svh"

module irq_pin_vector_dispatch_tb;
	import irq_pin_pkg::*;
	logic core_clk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0;
	logic [7:0] reg_addr_i = 8'h00;
	byte_t reg_wdata_i = 8'h00, reg_rdata_o;
	logic drv_en = 1, drv_val = 0, pin, pull_en, pull_dn, level, creq, irq;
	logic [31:0] other_req = 32'h0;
	logic gmask = 1, fetch_req = 0, vvalid, vhigh;
	vec_num_t vnum;
	addr_t vaddr;
	int num_errors = 0, n_compared = 0;

	// 100 ns clock
	initial begin
		forever #50 core_clk_i = ~core_clk_i;
	end

	request_pin_model request_pin_model_i (.drive_en_i(drv_en), .drive_val_i(drv_val),
		.pull_enable_i(pull_en), .pull_down_sel_i(pull_dn), .pin_o(pin));

	irq_pin_vector_dispatch irq_pin_vector_dispatch_i (.core_clk_i(core_clk_i),
		.resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.request_pin_i(pin), .pull_enable_o(pull_en), .pull_down_sel_o(pull_dn),
		.pin_level_o(level), .other_requests_i(other_req), .global_mask_i(gmask),
		.vector_fetch_i(fetch_req), .cpu_request_o(creq), .vector_valid_o(vvalid),
		.vector_num_o(vnum), .vector_addr_o(vaddr), .vector_byte_high_o(vhigh),
		.irq_o(irq));

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : cyc

	task wr(input logic [7:0] a, input byte_t d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask : wr

	// Read data stands only in the cycle after the strobe edge
	task rd(input logic [7:0] a, input byte_t e);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk("rdata", reg_rdata_o, e);
	endtask : rd

	// Pin change then enough edges for sync plus flag
	task pin_to(input logic v);
		@(posedge core_clk_i);
		drv_val <= v;
		cyc(5);
	endtask : pin_to

	task fetch(input vec_num_t n, input logic ok);
		@(posedge core_clk_i);
		fetch_req <= 1'b1;
		@(posedge core_clk_i);
		fetch_req <= 1'b0;
		#1 chk("valid", vvalid, ok);
		if (ok) begin
			chk("num", vnum, n);
			chk("hi", {vhigh, vaddr}, {1'b1, 16'hfffe - 16'(2 * n)});
			cyc(1);
			chk("lo", {vhigh, vaddr}, {1'b0, 16'hffff - 16'(2 * n)});
		end
	endtask : fetch

	task results;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	// Main sequence
	initial begin
		repeat (20) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		cyc(2);
		chk("vnum", vnum, 5'h1f);
		pin_to(1);
		pin_to(0);
		rd(8'h00, 8'h00);
		chk("pull", {pull_en, level}, 2'b00);
		$display("test disabled done");
		wr(8'h00, 8'h30);
		pin_to(1);
		chk("pulls", {pull_en, pull_dn}, 2'b11);
		chk("level", level, 1'b1);
		rd(8'h00, 8'h38);
		wr(8'h00, 8'h34);
		rd(8'h00, 8'h30);
		wr(8'h00, 8'h10);
		chk("pull_dn", pull_dn, 1'b0);
		pin_to(0);
		chk("level low", level, 1'b0);
		rd(8'h00, 8'h18);
		wr(8'h00, 8'h14);
		rd(8'h00, 8'h10);
		$display("test edges done");
		wr(8'h00, 8'h11);
		cyc(3);
		wr(8'h00, 8'h15);
		rd(8'h00, 8'h19);
		pin_to(1);
		wr(8'h00, 8'h15);
		rd(8'h00, 8'h11);
		$display("test level done");
		wr(8'h00, 8'h32);
		pin_to(0);
		pin_to(1);
		chk("creq", creq, 1'b1);
		wr(8'h00, 8'h30);
		cyc(1);
		chk("creq off", creq, 1'b0);
		rd(8'h00, 8'h38);
		wr(8'h00, 8'h32);
		wr(8'h02, 8'h01);
		cyc(1);
		chk("irq", irq, 1'b1);
		wr(8'h01, 8'h01);
		cyc(1);
		chk("irq clr", irq, 1'b0);
		$display("test interrupt done");
		@(posedge core_clk_i);
		other_req <= 32'hfc000020;
		fetch(5'h02, 1'b0);
		@(posedge core_clk_i);
		gmask <= 1'b0;
		fetch(5'h02, 1'b1);
		wr(8'h00, 8'h36);
		fetch(5'h05, 1'b1);
		rd(8'h03, 8'h05);
		rd(8'h01, 8'h02);
		@(posedge core_clk_i);
		other_req <= 32'hfc000000;
		fetch(5'h1f, 1'b0);
		rd(8'h07, 8'h00);
		$display("test vectors done");
		wr(8'h00, 8'h30);
		@(posedge core_clk_i);
		drv_en <= 1'b0;
		cyc(5);
		chk("released", level, 1'b0);
		@(posedge core_clk_i);
		drv_en <= 1'b1;
		resetn_i <= 1'b0;
		cyc(3);
		chk("reset", {vvalid, creq, irq, pull_en, vnum, vaddr}, {4'h0, 5'h1f, 16'hfffe});
		@(posedge core_clk_i);
		resetn_i <= 1'b1;
		cyc(2);
		rd(8'h00, 8'h00);
		$display("test release and reset done");
		results();
	end

	// Bound on the whole run
	initial begin
		repeat (5000) @(posedge core_clk_i);
		num_errors++;
		results();
	end
endmodule : irq_pin_vector_dispatch_tb

// ===== dv/request_pin_model.sv
// Far-side device driving the external request pin.
// Assumes the bench steers drive enable and level; pulls come from the block.
`timescale 1ns/10ps

module request_pin_model (
	// Stimulus from the bench
	input  wire logic drive_en_i,
	input  wire logic drive_val_i,
	// Pull resistor state from the block
	input  wire logic pull_enable_i,
	input  wire logic pull_down_sel_i,
	// Pin seen by the block
	output logic      pin_o
);
	// Released pin follows the pull, else the inverse of the last level
	// so a floating wire never looks like the old value
	always_comb begin
		if (drive_en_i)
			pin_o = drive_val_i;
		else if (pull_enable_i)
			pin_o = ~pull_down_sel_i;
		else
			pin_o = ~drive_val_i;
	end
endmodule : request_pin_model

// ===== logic/irq_pin_vector_dispatch.sv
// Request pin detection, event flag and fixed-priority vector dispatch.
// Assumes a single 10 MHz clock, a plain register port and a CPU that
// asks for a vector with one strobe once its global mask is clear.
//
// Functional notes
// [RULE1] Pin events only while pin enable set
// [RULE2] Polarity bit picks detected edge and level
// [RULE3] Mode picks edge only or edge-and-level
// [RULE4] Interrupt enable gates request, flag always set
// [RULE5] Rising polarity turns pull-up into pull-down
// [RULE6] CPU sees synchronised pin level when enabled
// [RULE7] Vectors 26 to 31 have no source
// [RULE8] Polarity one rising/high, zero falling/low
// [RULE9] Ack write one clears flag, reads zero
// [RULE10] Level mode: ack fails while pin asserted
// [RULE11] Highest pending source served first
// [RULE12] Lower number wins; high then low byte
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "irq_pin_defs.svh"

module irq_pin_vector_dispatch (
	// Clock and reset
	input  wire logic                 core_clk_i,
	input  wire logic                 resetn_i,
	// Register port
	input  wire logic [7:0]           reg_addr_i,
	input  wire irq_pin_pkg::byte_t   reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output irq_pin_pkg::byte_t        reg_rdata_o,
	// Request pin
	input  wire logic                 request_pin_i,
	output logic                      pull_enable_o,
	output logic                      pull_down_sel_o,
	// CPU side
	output logic                      pin_level_o,
	input  wire logic [31:0]          other_requests_i,
	input  wire logic                 global_mask_i,
	input  wire logic                 vector_fetch_i,
	output logic                      cpu_request_o,
	output logic                      vector_valid_o,
	output irq_pin_pkg::vec_num_t     vector_num_o,
	output irq_pin_pkg::addr_t        vector_addr_o,
	output logic                      vector_byte_high_o,
	// Interrupt line
	output logic                      irq_o
);
	import irq_pin_pkg::*;

	// Pin synchroniser and edge history
	logic       sync1_ff;
	logic       sync2_ff;
	logic       prev_ff;
	// Control bits
	logic       pin_en_ff;
	logic       polarity_ff;
	logic       mode_ff;
	logic       int_en_ff;
	logic       flag_ff;
	// Status and mask of the interrupt line
	logic [1:0] istat_ff;
	logic [1:0] imask_ff;
	// Vector dispatch
	fetch_state_t state_ff;
	vec_num_t     vec_ff;
	addr_t        vaddr_ff;
	byte_t        rdata_ff;

	// Pin passes two flops before anything reads it
	// Third flop is only edge history; logic never reads the first stage
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			prev_ff  <= 1'b0;
		end else begin
			sync1_ff <= request_pin_i;
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
		end
	end

	// Asserted level follows polarity: 1 high, 0 low
	wire pin_asserted = polarity_ff ? sync2_ff : ~sync2_ff; // [RULE2] [RULE8]
	wire prev_asserted = polarity_ff ? prev_ff : ~prev_ff;
	wire edge_seen = pin_asserted & ~prev_asserted;
	// Edge always counts, level only in edge-and-level mode
	wire event_seen = pin_en_ff & (edge_seen | (mode_ff & pin_asserted)); // [RULE1] [RULE3]

	// Register decode
	wire wr_ctrl  = reg_wr_i & (reg_addr_i == `REG_STATUS_CONTROL);
	wire wr_stat  = reg_wr_i & (reg_addr_i == `REG_IRQ_STATUS);
	wire wr_mask  = reg_wr_i & (reg_addr_i == `REG_IRQ_MASK);
	wire ack_wr   = wr_ctrl & reg_wdata_i[`BIT_ACKNOWLEDGE]; // [RULE9]
	// Level mode keeps flag while pin stays asserted
	wire ack_ok   = ack_wr & ~(mode_ff & pin_en_ff & pin_asserted); // [RULE10]

	// Control register; set wins over acknowledge
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			pin_en_ff   <= 1'b0;
			polarity_ff <= 1'b0;
			mode_ff     <= 1'b0;
			int_en_ff   <= 1'b0;
			flag_ff     <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				pin_en_ff   <= reg_wdata_i[`BIT_PIN_ENABLE];
				polarity_ff <= reg_wdata_i[`BIT_POLARITY];
				mode_ff     <= reg_wdata_i[`BIT_DETECT_MODE];
				int_en_ff   <= reg_wdata_i[`BIT_INT_ENABLE];
			end
			flag_ff <= event_seen | (flag_ff & ~ack_ok); // [RULE9]
		end
	end

	// Pull resistor and level read-back
	assign pull_enable_o   = pin_en_ff;
	assign pull_down_sel_o = pin_en_ff & polarity_ff; // [RULE5]
	assign pin_level_o     = pin_en_ff & sync2_ff; // [RULE6]

	// Hardware request only when enabled; flag alone is polled
	wire pin_request = flag_ff & int_en_ff; // [RULE4]
	assign cpu_request_o = pin_request;

	// Combined source list; user vector space carries no source
	wire [31:0] sources = {6'h00, other_requests_i[25:3], pin_request,
		other_requests_i[1:0]}; // [RULE7]

	// Lowest number wins among pending sources
	function automatic vec_num_t pick_lowest(input logic [31:0] req);
		vec_num_t v;
		v = `VEC_NONE;
		for (int i = `VEC_COUNT - 1; i >= 0; i--) begin
			if (req[i]) begin
				v = vec_num_t'(i);
			end
		end
		return v;
	endfunction : pick_lowest

	wire      any_pending = |sources;
	wire vec_num_t winner = pick_lowest(sources); // [RULE11] [RULE12]
	// Vector n sits at top minus 2n, high byte first
	wire addr_t winner_addr = `VEC_TOP_ADDR - addr_t'({winner, 1'b0}); // [RULE12]
	// Dispatch may start only from idle with the mask clear
	wire fetch_take = vector_fetch_i & ~global_mask_i & any_pending & (state_ff == FETCH_IDLE);

	// Dispatch: taken only with global mask clear
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			state_ff <= FETCH_IDLE;
			vec_ff   <= `VEC_NONE;
			vaddr_ff <= `VEC_TOP_ADDR;
		end else begin
			unique case (state_ff)
				FETCH_IDLE: begin
					if (fetch_take) begin
						state_ff <= FETCH_HIGH; // [RULE11]
						vec_ff   <= winner;
						vaddr_ff <= winner_addr;
					end
				end
				FETCH_HIGH: begin
					state_ff <= FETCH_LOW;
					vaddr_ff <= vaddr_ff + 16'h0001; // [RULE12]
				end
				FETCH_LOW: begin
					state_ff <= FETCH_IDLE;
				end
				default: begin // Unused code falls back to idle
					state_ff <= FETCH_IDLE;
				end
			endcase
		end
	end

	assign vector_valid_o     = (state_ff != FETCH_IDLE);
	assign vector_byte_high_o = (state_ff == FETCH_HIGH);
	assign vector_num_o       = vec_ff;
	assign vector_addr_o      = vaddr_ff;

	// Interrupt status: bit0 pin event, bit1 dispatch start; write one clears
	wire [1:0] ev = {fetch_take, event_seen};
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			istat_ff <= 2'b00;
			imask_ff <= 2'b00;
		end else begin
			istat_ff <= ev | (istat_ff & ~(wr_stat ? reg_wdata_i[1:0] : 2'b00));
			if (wr_mask) begin
				imask_ff <= reg_wdata_i[1:0];
			end
		end
	end
	assign irq_o = |(istat_ff & imask_ff);

	// Read mux; acknowledge always reads zero
	wire byte_t ctrl_view = {2'b00, polarity_ff, pin_en_ff, flag_ff, 1'b0, int_en_ff, mode_ff};
	wire byte_t rd_mux =
		(reg_addr_i == `REG_STATUS_CONTROL) ? ctrl_view :
		(reg_addr_i == `REG_IRQ_STATUS)     ? {6'h00, istat_ff} :
		(reg_addr_i == `REG_IRQ_MASK)       ? {6'h00, imask_ff} :
		(reg_addr_i == `REG_VECTOR_CODE)    ? {3'b000, vec_ff} : 8'h00;
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= reg_rd_i ? rd_mux : 8'h00;
		end
	end
	assign reg_rdata_o = rdata_ff;

	// Checks
	property p_flag_set;
		@(posedge core_clk_i) disable iff (!resetn_i) event_seen |=> flag_ff;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag missed event"); // [RULE1]
	property p_disabled;
		@(posedge core_clk_i) disable iff (!resetn_i)
			(!pin_en_ff && !flag_ff && !ack_wr) |=> !flag_ff;
	endproperty
	a_disabled: assert property (p_disabled) else $error("flag set while off"); // [RULE1]
	property p_level;
		@(posedge core_clk_i) disable iff (!resetn_i)
			(pin_en_ff && mode_ff && pin_asserted && ack_wr) |=> flag_ff;
	endproperty
	a_level: assert property (p_level) else $error("level ack cleared flag"); // [RULE10]
	property p_ack;
		@(posedge core_clk_i) disable iff (!resetn_i)
			(ack_ok && !event_seen) |=> !flag_ff;
	endproperty
	a_ack: assert property (p_ack) else $error("ack did not clear"); // [RULE9]
	property p_req;
		@(posedge core_clk_i) disable iff (!resetn_i) cpu_request_o == (flag_ff && int_en_ff);
	endproperty
	a_req: assert property (p_req) else $error("request gating wrong"); // [RULE4]
	property p_pull;
		@(posedge core_clk_i) disable iff (!resetn_i)
			pull_down_sel_o |-> (pin_en_ff && polarity_ff);
	endproperty
	a_pull: assert property (p_pull) else $error("pull direction wrong"); // [RULE5]
	property p_user;
		@(posedge core_clk_i) disable iff (!resetn_i)
			vector_valid_o |-> (vector_num_o < `VEC_USER_FIRST);
	endproperty
	a_user: assert property (p_user) else $error("user vector dispatched"); // [RULE7]
	property p_pair;
		@(posedge core_clk_i) disable iff (!resetn_i)
			vector_byte_high_o |=> (vector_valid_o && !vector_byte_high_o
				&& vector_addr_o == $past(vector_addr_o) + 16'h0001);
	endproperty
	a_pair: assert property (p_pair) else $error("vector pair broken"); // [RULE12]
	property p_rd_ack;
		@(posedge core_clk_i) disable iff (!resetn_i)
			(reg_rd_i && reg_addr_i == `REG_STATUS_CONTROL) |=> !reg_rdata_o[`BIT_ACKNOWLEDGE];
	endproperty
	a_rd_ack: assert property (p_rd_ack) else $error("ack read nonzero"); // [RULE9]
	// Edge sensing in both polarities; guards the sync-to-flag path
	property p_rise;
		@(posedge core_clk_i) disable iff (!resetn_i)
			(pin_en_ff && polarity_ff && sync2_ff && !prev_ff) |=> flag_ff;
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge missed"); // [RULE2]
	property p_fall;
		@(posedge core_clk_i) disable iff (!resetn_i)
			(pin_en_ff && !polarity_ff && !sync2_ff && prev_ff) |=> flag_ff;
	endproperty
	a_fall: assert property (p_fall) else $error("falling edge missed"); // [RULE8]
	// Edge-only mode must let a steady pin be acknowledged
	property p_edge_only;
		@(posedge core_clk_i) disable iff (!resetn_i)
			(pin_en_ff && !mode_ff && sync2_ff == prev_ff && ack_wr) |=> !flag_ff;
	endproperty
	a_edge_only: assert property (p_edge_only) else $error("edge mode ack refused"); // [RULE3]
	// Read-back lags the pin by exactly the two sync stages
	property p_level_rb;
		@(posedge core_clk_i) disable iff (!resetn_i)
			pin_en_ff |-> (pin_level_o == $past(sync1_ff));
	endproperty
	a_level_rb: assert property (p_level_rb) else $error("pin level wrong"); // [RULE6]
	// Dispatch start, masking and return to idle
	property p_start;
		@(posedge core_clk_i) disable iff (!resetn_i)
			fetch_take |=> (vector_byte_high_o
				&& vector_addr_o == `VEC_TOP_ADDR - 16'({vector_num_o, 1'b0}));
	endproperty
	a_start: assert property (p_start) else $error("vector address wrong"); // [RULE12]
	property p_masked;
		@(posedge core_clk_i) disable iff (!resetn_i)
			(global_mask_i && !vector_valid_o) |=> !vector_valid_o;
	endproperty
	a_masked: assert property (p_masked) else $error("masked fetch taken"); // [RULE11]
	property p_low_end;
		@(posedge core_clk_i) disable iff (!resetn_i)
			(vector_valid_o && !vector_byte_high_o) |=> !vector_valid_o;
	endproperty
	a_low_end: assert property (p_low_end) else $error("fetch overran low byte"); // [RULE12]
	// Pin vector beats every source numbered above it
	property p_pin_wins;
		@(posedge core_clk_i) disable iff (!resetn_i)
			(fetch_take && pin_request && other_requests_i[1:0] == 2'b00)
				|=> vector_num_o == `VEC_IRQ_PIN;
	endproperty
	a_pin_wins: assert property (p_pin_wins) else $error("pin vector lost priority"); // [RULE11]
endmodule : irq_pin_vector_dispatch

// ===== pkg/irq_pin_defs.svh
// Constants for the request pin status/control block and vector dispatch.
// Assumes inclusion by the package and the design file; definitions only.
`ifndef IRQ_PIN_DEFS_SVH
`define IRQ_PIN_DEFS_SVH

// Register offsets on the plain port (byte addresses)
`define REG_STATUS_CONTROL 8'h00
`define REG_IRQ_STATUS     8'h01
`define REG_IRQ_MASK       8'h02
`define REG_VECTOR_CODE    8'h03

// Status/control field positions
`define BIT_DETECT_MODE    0
`define BIT_INT_ENABLE     1
`define BIT_ACKNOWLEDGE    2
`define BIT_EVENT_FLAG     3
`define BIT_PIN_ENABLE     4
`define BIT_POLARITY       5

// Reset value of status/control and mask
`define CTRL_RESET         8'h00
`define MASK_RESET         8'h00

// Vector numbering
`define VEC_COUNT          32
`define VEC_IRQ_PIN        5'h02
`define VEC_USER_FIRST     5'h1a
`define VEC_TOP_ADDR       16'hfffe
`define VEC_NONE           5'h1f

`endif

// ===== pkg/irq_pin_pkg.sv
// Types shared by the request pin block.
// Assumes the constants header sits beside it.
`include "irq_pin_defs.svh"
package irq_pin_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [4:0]  vec_num_t;
	typedef logic [15:0] addr_t;
	// Vector fetch sequence, one bit flips per step except the return to idle
	typedef enum logic [1:0] {
		FETCH_IDLE = 2'b00,
		FETCH_HIGH = 2'b01,
		FETCH_LOW  = 2'b11
	} fetch_state_t;
endpackage : irq_pin_pkg
